/* File: verilog/port_pin_config_skip.sv */
// port-2 pin configuration and data logic plus the port-1 crossbar skip mask
`timescale 1ns/1ps
`include "port_cfg_consts.svh"

module port_pin_config_skip
    import port_cfg_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1,  // 1: all eight port-2 pins bonded out
    parameter int PORT_WIDTH = 8         // pins per port
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire sfr_req_type sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_rvalid_o,
    input wire logic [7:0] pin_in_i,
    output pad_ctrl_type pad_ctrl_o,
    output logic [7:0] xbar_skip_o
);

    // -------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------
    // the register map is byte wide; another width has no meaning here
    if (PORT_WIDTH != 8) begin : g_width_check
        $error("port_pin_config_skip: PORT_WIDTH must be 8");
    end

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    // pins that physically exist on the chosen package
    localparam logic [7:0] PRESENT_MASK = LARGE_PACKAGE ? `PINS_LARGE_MASK : `PINS_SMALL_MASK;

    logic [7:0] port_two_data_ff;        // output latch
    logic [7:0] port_two_drive_mode_ff;  // push-pull when one
    logic [7:0] port_one_skip_mask_ff;   // crossbar skip mask
    logic [7:0] port_two_input_mode_ff;  // digital when one
    logic [7:0] sync1_ff;                // first synchroniser stage
    logic [7:0] sync2_ff;                // second stage
    logic [7:0] sync3_ff;                // third stage
    logic [7:0] pin_level_ff;            // agreed pin level
    logic [7:0] rdata_ff;                // read data register
    logic rvalid_ff;                     // read answer flag
    pad_ctrl_type pad_ctrl_ff;           // registered pad controls
    pad_ctrl_type nxt_pad_ctrl;          // next pad controls
    logic [7:0] nxt_rdata;               // read mux output
    logic rd_hit;                        // read of a mapped register
    logic cfg_page;                      // configuration page selected
    logic [7:0] digital;                 // pins in digital mode and present
    logic [7:0] push_pull;               // pins actively driving both levels

    // -------------------------------------------------------------------
    // page and decode
    // -------------------------------------------------------------------
    // configuration registers only answer on one page
    assign cfg_page = (sfr_req_i.page == `CONFIG_PAGE);

    // effective pin modes; drive mode is masked out for analog pins
    assign digital = port_two_input_mode_ff & PRESENT_MASK;
    assign push_pull = port_two_drive_mode_ff & digital;

    // -------------------------------------------------------------------
    // output latch
    // -------------------------------------------------------------------
    // data register decodes on every page and takes single-bit writes too
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_two_data_ff <= `PORT_TWO_DATA_RST;
        end else if (sfr_req_i.wr && sfr_req_i.addr == `PORT_TWO_DATA_ADDR) begin
            // byte write loads every latch bit
            port_two_data_ff <= sfr_req_i.wdata;
        end else if (sfr_req_i.bit_wr) begin
            // bit write touches one latch bit only
            port_two_data_ff[sfr_req_i.bit_idx] <= sfr_req_i.bit_val;
        end
    end

    // -------------------------------------------------------------------
    // drive mode register
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_two_drive_mode_ff <= `PORT_TWO_DRIVE_MODE_RST;
        end else if (sfr_req_i.wr && cfg_page
                     && sfr_req_i.addr == `PORT_TWO_DRIVE_MODE_ADDR) begin
            port_two_drive_mode_ff <= sfr_req_i.wdata;
        end
    end

    // -------------------------------------------------------------------
    // crossbar skip mask
    // -------------------------------------------------------------------
    // the crossbar reads this mask straight; one hides the pin from it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_one_skip_mask_ff <= `PORT_ONE_SKIP_MASK_RST;
        end else if (sfr_req_i.wr && cfg_page
                     && sfr_req_i.addr == `PORT_ONE_SKIP_MASK_ADDR) begin
            port_one_skip_mask_ff <= sfr_req_i.wdata;
        end
    end

    assign xbar_skip_o = port_one_skip_mask_ff;

    // -------------------------------------------------------------------
    // input mode register
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_two_input_mode_ff <= `PORT_TWO_INPUT_MODE_RST;
        end else if (sfr_req_i.wr && cfg_page
                     && sfr_req_i.addr == `PORT_TWO_INPUT_MODE_ADDR) begin
            port_two_input_mode_ff <= sfr_req_i.wdata;
        end
    end

    // -------------------------------------------------------------------
    // pin input synchroniser
    // -------------------------------------------------------------------
    // three stages; the level moves only when stages two and three agree,
    // which filters a single-cycle glitch at the cost of one cycle latency
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_ff <= `PIN_SYNC_RST;
            sync2_ff <= `PIN_SYNC_RST;
            sync3_ff <= `PIN_SYNC_RST;
        end else begin
            sync1_ff <= pin_in_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // per-bit agreement between stages two and three
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_level_ff <= `PIN_SYNC_RST;
        end else begin
            for (int i = 0; i < PORT_WIDTH; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    pin_level_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------
    // data read returns pin levels, analog or absent pins read low
    always_comb begin
        nxt_rdata = 8'h00;
        rd_hit = 1'b0;
        case (sfr_req_i.addr)
            `PORT_TWO_DATA_ADDR: begin
                nxt_rdata = pin_level_ff & digital;
                rd_hit = 1'b1;
            end
            `PORT_TWO_DRIVE_MODE_ADDR: begin
                nxt_rdata = cfg_page ? port_two_drive_mode_ff : 8'h00;
                rd_hit = cfg_page;
            end
            `PORT_ONE_SKIP_MASK_ADDR: begin
                nxt_rdata = cfg_page ? port_one_skip_mask_ff : 8'h00;
                rd_hit = cfg_page;
            end
            `PORT_TWO_INPUT_MODE_ADDR: begin
                nxt_rdata = cfg_page ? port_two_input_mode_ff : 8'h00;
                rd_hit = cfg_page;
            end
            default: begin
                // other addresses belong to other blocks; stay silent
                nxt_rdata = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= `READ_DATA_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= (sfr_req_i.rd && rd_hit) ? nxt_rdata : 8'h00;
            rvalid_ff <= sfr_req_i.rd && rd_hit;
        end
    end

    assign sfr_rdata_o = rdata_ff;
    assign sfr_rvalid_o = rvalid_ff;

    // -------------------------------------------------------------------
    // pad control
    // -------------------------------------------------------------------
    // push-pull drives both levels; open-drain drives low only;
    // analog and absent pins are fully released
    always_comb begin
        nxt_pad_ctrl.out = port_two_data_ff & digital;
        nxt_pad_ctrl.oe_n = ~(push_pull | (digital & ~port_two_data_ff));
        nxt_pad_ctrl.pullup_en = digital;
        nxt_pad_ctrl.rx_en = digital;
    end

    // registered so the pads never see decode glitches
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pad_ctrl_ff.out <= `PAD_OFF_RST;
            pad_ctrl_ff.oe_n <= `PAD_RELEASED_RST;
            pad_ctrl_ff.pullup_en <= `PAD_OFF_RST;
            pad_ctrl_ff.rx_en <= `PAD_OFF_RST;
        end else begin
            pad_ctrl_ff <= nxt_pad_ctrl;
        end
    end

    assign pad_ctrl_o = pad_ctrl_ff;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    // skip write on the configuration page lands next cycle
    AST_SKIP_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sfr_req_i.wr && sfr_req_i.page == `CONFIG_PAGE
         && sfr_req_i.addr == `PORT_ONE_SKIP_MASK_ADDR)
        |=> (xbar_skip_o == $past(sfr_req_i.wdata)))
        else $error("skip mask did not take the write");

    // configuration writes on another page leave registers untouched
    AST_WRONG_PAGE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sfr_req_i.wr && sfr_req_i.page != `CONFIG_PAGE
         && (sfr_req_i.addr == `PORT_ONE_SKIP_MASK_ADDR
             || sfr_req_i.addr == `PORT_TWO_INPUT_MODE_ADDR
             || sfr_req_i.addr == `PORT_TWO_DRIVE_MODE_ADDR))
        |=> ($stable(port_one_skip_mask_ff) && $stable(port_two_input_mode_ff)
             && $stable(port_two_drive_mode_ff)))
        else $error("configuration register changed off its page");

    // data byte write works on any page
    AST_DATA_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sfr_req_i.wr && sfr_req_i.addr == `PORT_TWO_DATA_ADDR)
        |=> (port_two_data_ff == $past(sfr_req_i.wdata)))
        else $error("output latch missed a byte write");

    // single-bit write sets the addressed bit to its value
    AST_BIT_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sfr_req_i.bit_wr && !(sfr_req_i.wr && sfr_req_i.addr == `PORT_TWO_DATA_ADDR))
        |=> (port_two_data_ff[$past(sfr_req_i.bit_idx)] == $past(sfr_req_i.bit_val)))
        else $error("bit write did not reach the latch");

    // data read answers with pin levels of digital pins
    AST_DATA_READ: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sfr_req_i.rd && sfr_req_i.addr == `PORT_TWO_DATA_ADDR)
        |=> (sfr_rvalid_o && sfr_rdata_o == $past(pin_level_ff & digital)))
        else $error("data read did not return pin levels");

    // drive mode write on the configuration page lands next cycle
    AST_DRIVE_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sfr_req_i.wr && sfr_req_i.page == `CONFIG_PAGE
         && sfr_req_i.addr == `PORT_TWO_DRIVE_MODE_ADDR)
        |=> (port_two_drive_mode_ff == $past(sfr_req_i.wdata)))
        else $error("drive mode register did not take the write");

    // input mode reads off the configuration page stay unanswered
    AST_READ_REFUSED: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sfr_req_i.rd && sfr_req_i.page != `CONFIG_PAGE
         && sfr_req_i.addr == `PORT_TWO_INPUT_MODE_ADDR)
        |=> !sfr_rvalid_o)
        else $error("configuration register answered off its page");

    // analog pins are released with pull-up and receiver off
    AST_ANALOG_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 (((pad_ctrl_o.oe_n & ~$past(port_two_input_mode_ff)) == ~$past(port_two_input_mode_ff))
             && ((pad_ctrl_o.pullup_en | pad_ctrl_o.rx_en)
                 & ~$past(port_two_input_mode_ff)) == 8'h00))
        else $error("analog pin still driven or pulled up");

    // push-pull digital pins drive the latch value
    AST_PUSH_PULL: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 (((pad_ctrl_o.oe_n & $past(push_pull)) == 8'h00)
             && ((pad_ctrl_o.out & $past(push_pull))
                 == ($past(port_two_data_ff) & $past(push_pull)))))
        else $error("push-pull pin not driving the latch");

    // open-drain pin with latch high is released
    AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 ((pad_ctrl_o.oe_n & $past(digital & ~port_two_drive_mode_ff & port_two_data_ff))
             == $past(digital & ~port_two_drive_mode_ff & port_two_data_ff)))
        else $error("open-drain pin drove a high level");

    // absent pins never drive
    AST_ABSENT_PINS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pad_ctrl_o.oe_n | PRESENT_MASK) == 8'hFF)
        else $error("absent pin is being driven");

endmodule

/* File: verilog/port_cfg_consts.svh */
// register offsets, page code, reset values and pin presence masks for the port block
`ifndef PORT_CFG_CONSTS_SVH
`define PORT_CFG_CONSTS_SVH

// -----------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------
`define PORT_TWO_DATA_ADDR 8'hA0
`define PORT_TWO_DRIVE_MODE_ADDR 8'hA6
`define PORT_ONE_SKIP_MASK_ADDR 8'hD5
`define PORT_TWO_INPUT_MODE_ADDR 8'hF3

// -----------------------------------------------------------------------
// register page holding the configuration registers
// -----------------------------------------------------------------------
`define CONFIG_PAGE 8'h0F

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define PORT_TWO_DATA_RST 8'hFF
`define PORT_TWO_DRIVE_MODE_RST 8'h00
`define PORT_ONE_SKIP_MASK_RST 8'h00
`define PORT_TWO_INPUT_MODE_RST 8'hFF
`define PIN_SYNC_RST 8'hFF
`define PAD_RELEASED_RST 8'hFF
`define PAD_OFF_RST 8'h00
`define READ_DATA_RST 8'h00

// -----------------------------------------------------------------------
// pin presence per package option
// -----------------------------------------------------------------------
`define PINS_LARGE_MASK 8'hFF
`define PINS_SMALL_MASK 8'h03

`endif

/* File: verilog/port_cfg_pkg.sv */
// types shared by the port configuration block
package port_cfg_pkg;

    // -------------------------------------------------------------------
    // register access port: byte access and single-bit access
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;     // register address
        logic [7:0] page;     // currently selected register page
        logic wr;             // byte write strobe
        logic rd;             // byte read strobe
        logic [7:0] wdata;    // byte write data
        logic bit_wr;         // single-bit write to the data register
        logic [2:0] bit_idx;  // bit position for the single-bit write
        logic bit_val;        // value for the single-bit write
    } sfr_req_type;

    // -------------------------------------------------------------------
    // per-pin pad controls towards the board
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] out;        // level driven when enabled
        logic [7:0] oe_n;       // low while the pad drives
        logic [7:0] pullup_en;  // weak pull-up enable
        logic [7:0] rx_en;      // digital input receiver enable
    } pad_ctrl_type;

endpackage

/* File: bench/board_pins.sv */
// board-side model of the circuitry hanging on the port-2 pins
`timescale 1ns/1ps

module board_pins
    import port_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire pad_ctrl_type pads_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pin_o
);
    // -------------------------------------------------------------------
    // wire level
    // -------------------------------------------------------------------
    // undriven pins wander so a stale level is never read back by luck
    logic [7:0] float_ff = 8'h55;

    // toggles every cycle, no reset needed
    always_ff @(posedge clk_i) begin
        float_ff <= ~float_ff;
    end

    // pad drive wins, then board drivers, then the weak pull-up
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (!pads_i.oe_n[n]) begin
                pin_o[n] = pads_i.out[n];
            end else if (ext_en_i[n]) begin
                pin_o[n] = ext_val_i[n];
            end else if (pads_i.pullup_en[n]) begin
                pin_o[n] = 1'b1;
            end else begin
                pin_o[n] = float_ff[n];
            end
        end
    end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the port-2 configuration and port-1 skip block
`timescale 1ns/1ps
`include "port_cfg_consts.svh"

module tb_top
    import port_cfg_pkg::*;
;
    // -------------------------------------------------------------------
    // signals
    // -------------------------------------------------------------------
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    sfr_req_type req = '0; // shared by both package options
    logic [7:0] rdata_l, rdata_s, skip_l, pins, ext_en = 8'h00, ext_val = 8'h00;
    logic rvalid_l, rvalid_s;
    pad_ctrl_type pads_l, pads_s;
    logic [7:0] d, ds; // last read data, large and small
    logic v; // last read valid
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // one row: mode, drive, latch, board drive, then expected pads and read
    typedef struct packed {
        logic [7:0] mdin, mdout, latch, xen, xval, oe_n, out, rd;
    } row_type;
    row_type rows [5] = '{
        '{8'hFF, 8'hFF, 8'hA5, 8'h00, 8'h00, 8'h00, 8'hA5, 8'hA5},
        '{8'hFF, 8'h00, 8'h5A, 8'h5A, 8'h00, 8'h5A, 8'h00, 8'h00},
        '{8'h0F, 8'hF0, 8'hFF, 8'hF0, 8'hF0, 8'hFF, 8'h00, 8'h0F},
        '{8'hFF, 8'h0F, 8'h33, 8'h00, 8'h00, 8'h30, 8'h03, 8'h33},
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00}
    };

    always #20 clk_i = ~clk_i;

    // -------------------------------------------------------------------
    // design, small package copy sharing the same pins, board
    // -------------------------------------------------------------------
    port_pin_config_skip #(.LARGE_PACKAGE(1'b1), .PORT_WIDTH(8)) port_pin_config_skip_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(req), .sfr_rdata_o(rdata_l),
        .sfr_rvalid_o(rvalid_l), .pin_in_i(pins), .pad_ctrl_o(pads_l), .xbar_skip_o(skip_l));
    port_pin_config_skip #(.LARGE_PACKAGE(1'b0), .PORT_WIDTH(8)) port_pin_config_skip_s_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(req), .sfr_rdata_o(rdata_s),
        .sfr_rvalid_o(rvalid_s), .pin_in_i(pins), .pad_ctrl_o(pads_s), .xbar_skip_o());
    board_pins board_pins_i (
        .clk_i(clk_i), .pads_i(pads_l), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pins));

    // -------------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one request held for exactly one sampling edge; returns at that edge
    task automatic go(input sfr_req_type r);
        @(posedge clk_i);
        req <= r;
        @(posedge clk_i);
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] w);
        go('{a, p, 1'b1, 1'b0, w, 1'b0, 3'h0, 1'b0});
    endtask

    // answer stands for the cycle after the read edge only
    task automatic rd(input logic [7:0] a, input logic [7:0] p);
        go('{a, p, 1'b0, 1'b1, 8'h00, 1'b0, 3'h0, 1'b0});
        #1;
        d = rdata_l;
        ds = rdata_s;
        v = rvalid_l;
    endtask

    // hang guard, the whole run needs about 150 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        cmp8(skip_l, 8'h00);
        cmp8(pads_l.oe_n, 8'hFF);
        cmp8(pads_s.pullup_en, 8'h03);
        rd(`PORT_TWO_DATA_ADDR, 8'h00);
        cmp8(d, 8'hFF);
        rd(`PORT_TWO_DRIVE_MODE_ADDR, `CONFIG_PAGE);
        cmp8(d, 8'h00);
        // writes and reads off the configuration page are refused
        wr(`PORT_ONE_SKIP_MASK_ADDR, 8'h00, 8'hFF);
        wr(`PORT_TWO_INPUT_MODE_ADDR, 8'h0E, 8'h00);
        #1;
        cmp8(skip_l, 8'h00);
        rd(`PORT_TWO_INPUT_MODE_ADDR, 8'h00);
        cmp1(v, 1'b0);
        rd(8'h55, `CONFIG_PAGE);
        cmp1(v, 1'b0);
        rd(`PORT_TWO_INPUT_MODE_ADDR, `CONFIG_PAGE);
        cmp8(d, 8'hFF);
        foreach (rows[i]) begin
            wr(`PORT_TWO_INPUT_MODE_ADDR, `CONFIG_PAGE, rows[i].mdin);
            wr(`PORT_TWO_DRIVE_MODE_ADDR, `CONFIG_PAGE, rows[i].mdout);
            wr(`PORT_TWO_DATA_ADDR, 8'h03, rows[i].latch);
            wr(`PORT_ONE_SKIP_MASK_ADDR, `CONFIG_PAGE, rows[i].latch);
            ext_en <= rows[i].xen;
            ext_val <= rows[i].xval;
            #1;
            cmp8(skip_l, rows[i].latch);
            repeat (8) @(posedge clk_i);
            #1;
            cmp8(pads_l.oe_n, rows[i].oe_n);
            cmp8(pads_l.out & ~rows[i].oe_n, rows[i].out);
            cmp8(pads_l.pullup_en, rows[i].mdin);
            cmp8(pads_l.rx_en, rows[i].mdin);
            cmp8(pads_s.oe_n, rows[i].oe_n | 8'hFC);
            cmp8(pads_s.pullup_en, rows[i].mdin & 8'h03);
            rd(`PORT_TWO_DATA_ADDR, 8'h03);
            cmp1(v, 1'b1);
            cmp8(d, rows[i].rd);
            cmp8(ds, rows[i].rd & 8'h03);
            rd(`PORT_TWO_DRIVE_MODE_ADDR, `CONFIG_PAGE);
            cmp8(d, rows[i].mdout);
        end
        // single-bit access, then byte write racing a bit write
        ext_en <= 8'h00;
        wr(`PORT_TWO_INPUT_MODE_ADDR, `CONFIG_PAGE, 8'hFF);
        wr(`PORT_TWO_DRIVE_MODE_ADDR, `CONFIG_PAGE, 8'hFF);
        go('{8'h55, 8'h03, 1'b0, 1'b0, 8'h00, 1'b1, 3'h7, 1'b1});
        repeat (2) @(posedge clk_i);
        #1;
        cmp8(pads_l.out, 8'h80);
        go('{`PORT_TWO_DATA_ADDR, 8'h00, 1'b1, 1'b0, 8'h0F, 1'b1, 3'h7, 1'b1});
        repeat (2) @(posedge clk_i);
        #1;
        cmp8(pads_l.out, 8'h0F);
        // reset in mid-run returns every register to its reset value
        wr(`PORT_ONE_SKIP_MASK_ADDR, `CONFIG_PAGE, 8'hFF);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        cmp8(pads_l.oe_n, 8'hFF);
        cmp8(skip_l, 8'h00);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(`PORT_TWO_INPUT_MODE_ADDR, `CONFIG_PAGE);
        cmp8(d, 8'hFF);
        rd(`PORT_TWO_DATA_ADDR, 8'h00);
        cmp8(d, 8'hFF);
        tally_and_finish();
    end
endmodule
